// [rtl/rrx_pkg.sv]
// Shared constants, states and carriers for the return and rotate executor
`default_nettype none
package rrx_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   localparam int PC_W = 21;
   localparam int BSR_W = 4;
   localparam int STAT_W = 5;
   // Opcode patterns
   localparam logic [7:0] OPC_LIT_RET = 8'h0c;
   localparam logic [14:0] OPC_SUB_RET = 15'h0009;
   localparam logic [5:0] OPC_ROT_CARRY = 6'h0d;
   localparam logic [5:0] OPC_ROT_PLAIN = 6'h11;
   // Instruction field positions
   localparam int POS_DEST = 9;
   localparam int POS_ACCESS = 8;
   localparam int POS_SHADOW = 0;
   // Status flag positions
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_OV = 3;
   localparam int ST_N = 4;
   // Access bank split and indexed window
   localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [BSR_W-1:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [BSR_W-1:0] ACCESS_HIGH_BANK = 4'hf;
   // Reset values
   localparam logic [DATA_W-1:0] W_RST = 8'h00;
   localparam logic [STAT_W-1:0] STATUS_RST = 5'h00;
   localparam logic [BSR_W-1:0] BSR_RST = 4'h0;
   localparam logic [PC_W-1:0] PC_RST = 21'h000000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RET2 = 2'b01,
      ST_ROT_RD = 2'b10,
      ST_ROT_EX = 2'b11
   } rrx_state_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } rrx_rf_req_t;

   typedef struct packed {
      logic pop;
      logic pc_load;
      logic [PC_W-1:0] pc_val;
   } rrx_flow_t;

   typedef struct packed {
      logic [DATA_W-1:0] w;
      logic [STAT_W-1:0] status;
      logic [BSR_W-1:0] bank_select_reg;
   } rrx_ctx_t;

   typedef struct packed {
      rrx_state_t st;
      logic dest_file;
      logic thru_carry;
      rrx_ctx_t ctx;
      rrx_rf_req_t rf;
      rrx_flow_t flow;
   } rrx_regs_t;
endpackage
`default_nettype wire

// [rtl/rrx_rotate_unit.sv]
// Left rotator with flag results for both rotate forms
`default_nettype none
module rrx_rotate_unit
   import rrx_pkg::*;
(
   input wire logic thru_carry,
   input wire logic [DATA_W-1:0] src,
   input wire logic carry_in,
   output logic [DATA_W-1:0] result,
   output logic carry_out,
   output logic neg,
   output logic zero
);
   always_comb begin
      // Bit 0 refills from the old carry or from the bit shifted out
      result = {src[DATA_W-2:0], thru_carry ? carry_in : src[DATA_W-1]};
      carry_out = src[DATA_W-1];
      neg = result[DATA_W-1];
      zero = (result == '0);
   end
endmodule // rrx_rotate_unit
`default_nettype wire

// [rtl/rrx_exec.sv]
// Executor for literal return, subroutine return and the two left rotates
`default_nettype none
module rrx_exec
   import rrx_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   output logic instr_ready,
   input wire logic ext_set_en,
   input wire logic [ADDR_W-1:0] index_base,
   input wire logic [PC_W-1:0] stack_top_entry,
   input wire rrx_ctx_t shadow_ctx,
   input wire logic [DATA_W-1:0] rf_rdata,
   output rrx_rf_req_t rf_req,
   output rrx_flow_t flow,
   output rrx_ctx_t ctx
);
   rrx_regs_t r_q;
   rrx_regs_t r_d;
   logic take;
   logic is_lit_ret;
   logic is_sub_ret;
   logic is_rot_c;
   logic is_rot_p;
   logic [7:0] f_addr;
   logic [ADDR_W-1:0] eff_addr;
   logic [DATA_W-1:0] rot_res;
   logic rot_c;
   logic rot_n;
   logic rot_z;

   assign instr_ready = (r_q.st == ST_IDLE);
   assign take = instr_valid && instr_ready;
   assign f_addr = instr_word[7:0];
   assign is_lit_ret = (instr_word[15:8] == OPC_LIT_RET);
   assign is_sub_ret = (instr_word[15:1] == OPC_SUB_RET);
   assign is_rot_c = (instr_word[15:10] == OPC_ROT_CARRY);
   assign is_rot_p = (instr_word[15:10] == OPC_ROT_PLAIN);

   // Operand address
   always_comb begin
      if (instr_word[POS_ACCESS]) begin
         eff_addr = {r_q.ctx.bank_select_reg, f_addr};
      end else if (ext_set_en && (f_addr <= INDEXED_LIMIT)) begin
         eff_addr = index_base + {4'h0, f_addr};
      end else if (f_addr < ACCESS_SPLIT) begin
         eff_addr = {ACCESS_LOW_BANK, f_addr};
      end else begin
         eff_addr = {ACCESS_HIGH_BANK, f_addr};
      end
   end

   rrx_rotate_unit u_rot (
      .thru_carry(r_q.thru_carry),
      .src(rf_rdata),
      .carry_in(r_q.ctx.status[ST_C]),
      .result(rot_res),
      .carry_out(rot_c),
      .neg(rot_n),
      .zero(rot_z)
   );

   always_comb begin
      r_d = r_q;
      // Strobes last one cycle
      r_d.rf.rd = 1'b0;
      r_d.rf.wr = 1'b0;
      r_d.flow.pop = 1'b0;
      r_d.flow.pc_load = 1'b0;
      case (r_q.st)
         ST_IDLE: begin
            if (take && is_lit_ret) begin
               r_d.ctx.w = instr_word[7:0];
               r_d.flow.pop = 1'b1;
               r_d.flow.pc_load = 1'b1;
               r_d.flow.pc_val = stack_top_entry;
               r_d.st = ST_RET2;
            end else if (take && is_sub_ret) begin
               r_d.flow.pop = 1'b1;
               r_d.flow.pc_load = 1'b1;
               r_d.flow.pc_val = stack_top_entry;
               // Clear shadow bit keeps the live context
               if (instr_word[POS_SHADOW]) begin
                  r_d.ctx = shadow_ctx;
               end
               r_d.st = ST_RET2;
            end else if (take && (is_rot_c || is_rot_p)) begin
               r_d.rf.rd = 1'b1;
               r_d.rf.addr = eff_addr;
               r_d.dest_file = instr_word[POS_DEST];
               r_d.thru_carry = is_rot_c;
               r_d.st = ST_ROT_RD;
            end
         end
         // Second cycle of a return is a dead slot
         ST_RET2: begin
            r_d.st = ST_IDLE;
         end
         ST_ROT_RD: begin
            r_d.st = ST_ROT_EX;
         end
         ST_ROT_EX: begin
            if (r_q.dest_file) begin
               r_d.rf.wr = 1'b1;
               r_d.rf.wdata = rot_res;
            end else begin
               r_d.ctx.w = rot_res;
            end
            r_d.ctx.status[ST_N] = rot_n;
            r_d.ctx.status[ST_Z] = rot_z;
            if (r_q.thru_carry) begin
               r_d.ctx.status[ST_C] = rot_c;
            end
            r_d.st = ST_IDLE;
         end
         default: begin
            r_d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         r_q.st <= ST_IDLE;
         r_q.dest_file <= 1'b1;
         r_q.thru_carry <= 1'b0;
         r_q.ctx <= '{w: W_RST, status: STATUS_RST, bank_select_reg: BSR_RST};
         r_q.rf <= '0;
         r_q.flow <= '{pop: 1'b0, pc_load: 1'b0, pc_val: PC_RST};
      end else begin
         r_q <= r_d;
      end
   end

   assign rf_req = r_q.rf;
   assign flow = r_q.flow;
   assign ctx = r_q.ctx;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_rot_take;
      take && (is_rot_c || is_rot_p);
   endsequence
   sequence s_ex_file;
      r_q.st == ST_ROT_EX && r_q.dest_file;
   endsequence
   sequence s_ret_take;
      take && (is_lit_ret || is_sub_ret);
   endsequence

   // Return checks, then rotate timing and carry rotate checks

   chk_litret_w: assert property (take && is_lit_ret |=> ctx.w == $past(instr_word[7:0]))
      else $error("literal return did not load accumulator");
   chk_litret_pc: assert property (take && is_lit_ret |=> flow.pop && flow.pc_load &&
      flow.pc_val == $past(stack_top_entry)) else $error("literal return did not pop to counter");
   chk_ret_no_write: assert property (s_ret_take |=> (!rf_req.wr)[*2])
      else $error("return wrote the register file");
   // Ready is low only in the dead slot, back in the cycle after
   chk_subret_pop: assert property (take && is_sub_ret |=>
      flow.pop && !instr_ready ##1 !flow.pop && instr_ready) else $error("subroutine return pop timing wrong");
   chk_litret_ready: assert property (take && is_lit_ret |=> !instr_ready ##1 instr_ready)
      else $error("literal return ready timing wrong");
   chk_shadow_load: assert property (take && is_sub_ret && instr_word[0] |=> ctx == $past(shadow_ctx))
      else $error("shadow values not restored");
   chk_shadow_keep: assert property (take && is_sub_ret && !instr_word[0] |=> $stable(ctx))
      else $error("return without shadow changed context");
   chk_rot_seq: assert property (s_rot_take |=> rf_req.rd ##1 !rf_req.rd ##1 instr_ready)
      else $error("rotate sequence timing wrong");
   chk_rlc_data: assert property (s_ex_file ##0 r_q.thru_carry |=> rf_req.wr &&
      rf_req.wdata == {$past(rf_rdata[6:0]), $past(r_q.ctx.status[ST_C])}) else $error("carry rotate result wrong");
   chk_rlc_flags: assert property (r_q.st == ST_ROT_EX && r_q.thru_carry |=>
      ctx.status[ST_C] == $past(rf_rdata[7]) && $stable(ctx.status[ST_OV]) && $stable(ctx.status[ST_DC]))
      else $error("carry rotate flags wrong");
   // Rotate checks
   chk_dest_w: assert property (r_q.st == ST_ROT_EX && !r_q.dest_file |=> !rf_req.wr &&
      ctx.w[DATA_W-1:1] == $past(rf_rdata[6:0]) && $stable(rf_req.wdata) &&
      ctx.w[0] == ($past(r_q.thru_carry) ? $past(r_q.ctx.status[ST_C]) : $past(rf_rdata[7])))
      else $error("accumulator destination wrong");
   chk_bank_addr: assert property (s_rot_take ##0 instr_word[8] |=>
      rf_req.addr == {$past(r_q.ctx.bank_select_reg), $past(instr_word[7:0])}) else $error("banked address wrong");
   chk_indexed: assert property (s_rot_take ##0 !instr_word[8] && ext_set_en && instr_word[7:0] <= INDEXED_LIMIT |=>
      rf_req.addr == $past(index_base) + {4'h0, $past(instr_word[7:0])}) else $error("indexed address wrong");
   chk_rln: assert property (s_ex_file ##0 !r_q.thru_carry |=>
      rf_req.wdata == {$past(rf_rdata[6:0]), $past(rf_rdata[7])} && $stable(ctx.status[ST_C]))
      else $error("plain rotate wrong");
   chk_rlc_nz: assert property (r_q.st == ST_ROT_EX && r_q.thru_carry |=>
      ctx.status[ST_N] == $past(rf_rdata[6]) &&
      ctx.status[ST_Z] == ($past(rf_rdata[6:0]) == 7'h00 && !$past(r_q.ctx.status[ST_C])))
      else $error("carry rotate N or Z wrong");
   chk_rln_flags: assert property (r_q.st == ST_ROT_EX && !r_q.thru_carry |=>
      ctx.status[ST_N] == $past(rf_rdata[6]) && ctx.status[ST_Z] == ($past(rf_rdata) == 8'h00) &&
      $stable(ctx.status[ST_OV]) && $stable(ctx.status[ST_DC])) else $error("plain rotate flags wrong");
   chk_access_low: assert property (s_rot_take ##0 !instr_word[POS_ACCESS] &&
      !(ext_set_en && instr_word[7:0] <= INDEXED_LIMIT) |=> rf_req.addr[7:0] == $past(instr_word[7:0]) &&
      rf_req.addr[ADDR_W-1:8] == ($past(instr_word[7:0]) < ACCESS_SPLIT ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK))
      else $error("access bank address wrong");
   chk_dest_file: assert property (s_ex_file |=> $stable(ctx.w))
      else $error("file destination changed accumulator");
   chk_wr_source: assert property (rf_req.wr |-> $past(r_q.st) == ST_ROT_EX && $past(r_q.dest_file))
      else $error("register write outside rotate");
   // Unrecognised words are swallowed so the decoder never stalls on them
   chk_unknown_op: assert property (take && !(is_lit_ret || is_sub_ret || is_rot_c || is_rot_p) |=>
      instr_ready && $stable(ctx) && !flow.pop && !flow.pc_load && !rf_req.rd)
      else $error("unrecognised opcode had an effect");
   chk_pc_hold: assert property ($changed(flow.pc_val) |-> flow.pc_load)
      else $error("counter value moved without a return");
endmodule // rrx_exec
`default_nettype wire

// [sim/return_and_rotate_instr_exec_test.sv]
// Self-checking bench for the return and rotate executor
`default_nettype none
module return_and_rotate_instr_exec_test import rrx_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, rst_b, instr_valid, instr_ready, ext_set_en;
   logic [15:0] instr_word;
   logic [ADDR_W-1:0] index_base;
   logic [PC_W-1:0] stack_top_entry;
   logic [DATA_W-1:0] rf_rdata;
   rrx_ctx_t shadow_ctx, ctx;
   rrx_rf_req_t rf_req;
   rrx_flow_t flow;
   integer err_count = 0, compares = 0, seed = 51, m_w, m_st, m_bsr, i;
   logic [7:0] m_wd, fv;
   rrx_exec u_dut (.core_clk(core_clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_word(instr_word),
      .instr_ready(instr_ready), .ext_set_en(ext_set_en), .index_base(index_base),
      .stack_top_entry(stack_top_entry), .shadow_ctx(shadow_ctx), .rf_rdata(rf_rdata),
      .rf_req(rf_req), .flow(flow), .ctx(ctx));
   initial begin
      core_clk = 0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask
   task automatic report(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_ctx;
      report(ctx, {m_w[7:0], m_st[4:0], m_bsr[3:0]});
   endtask
   task automatic cmp_flow(input rrx_flow_t e);
      report(flow, e);
   endtask
   task automatic cmp_rf(input rrx_rf_req_t e);
      report(rf_req, e);
   endtask
   task automatic cmp_ready(input logic e);
      report(instr_ready, e);
   endtask
   task automatic print_verdict;
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic take(input logic [15:0] w);
      integer n;
      n = 0;
      while (instr_ready !== 1'b1 && n < 8) begin
         tick;
         n++;
      end
      if (n == 8) begin
         err_count++;
         print_verdict;
      end
      instr_valid = 1;
      instr_word = w;
      tick;
      instr_valid = 0;
      instr_word = 16'($random(seed));
      stack_top_entry = 21'($random(seed));
      shadow_ctx = 17'($random(seed));
   endtask
   // Both return kinds share the two-cycle check
   task automatic ret(input logic lit, input logic s);
      logic [PC_W-1:0] pc;
      logic [7:0] k;
      pc = stack_top_entry;
      k = 8'($random(seed));
      if (lit) m_w = {24'h0, k};
      else if (s) {m_w, m_st, m_bsr} = {24'h0, shadow_ctx[16:9], 27'h0, shadow_ctx[8:4], 28'h0, shadow_ctx[3:0]};
      take(lit ? {OPC_LIT_RET, k} : {OPC_SUB_RET, s});
      cmp_flow({2'b11, pc});
      cmp_ctx();
      cmp_ready(1'b0);
      tick;
      cmp_flow({2'b00, pc});
      cmp_ready(1'b1);
   endtask
   task automatic rot(input logic cy, input logic d, input logic a, input logic [7:0] f, input logic [7:0] src);
      logic [11:0] ad;
      logic [7:0] r;
      ad = a ? {m_bsr[3:0], f} : (ext_set_en && f <= INDEXED_LIMIT) ? index_base + {4'h0, f} :
         (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HIGH_BANK, f};
      r = {src[6:0], cy ? m_st[0] : src[7]};
      take({cy ? OPC_ROT_CARRY : OPC_ROT_PLAIN, d, a, f});
      cmp_rf({2'b10, ad, m_wd});
      cmp_ready(1'b0);
      tick;
      rf_rdata = src;
      cmp_rf({2'b00, ad, m_wd});
      cmp_ready(1'b0);
      tick;
      rf_rdata = ~src;
      cmp_ready(1'b1);
      if (cy) m_st[0] = src[7];
      m_st[4] = r[7];
      m_st[2] = (r == 8'h00);
      if (d) m_wd = r;
      else m_w = {24'h0, r};
      cmp_rf({1'b0, d, ad, m_wd});
      cmp_ctx();
   endtask
   initial begin
      rst_b = 0;
      instr_valid = 0;
      instr_word = 16'h0000;
      ext_set_en = 0;
      index_base = 12'h000;
      stack_top_entry = 21'h000000;
      shadow_ctx = 17'h00000;
      rf_rdata = 8'h00;
      {m_w, m_st, m_bsr, m_wd} = '0;
      repeat (6) @(posedge core_clk);
      #1;
      rst_b = 1;
      repeat (4) ret(1, 0);
      $display("literal return test done");
      for (i = 0; i < 8; i++) ret(0, i[0]);
      $display("subroutine return test done");
      for (i = 0; i < 128; i++) begin
         ext_set_en = i[3];
         index_base = 12'($random(seed));
         case (i[5:4])
            2'd0: fv = INDEXED_LIMIT;
            2'd1: fv = ACCESS_SPLIT;
            2'd2: fv = 8'h00;
            default: fv = 8'($random(seed));
         endcase
         if (i[6]) ret(0, 1);
         rot(i[0], i[1], i[2], fv, 8'($random(seed)));
      end
      $display("rotate test done");
      take(16'hffff);
      tick;
      cmp_ctx();
      rst_b = 0;
      tick;
      rst_b = 1;
      {m_w, m_st, m_bsr, m_wd} = '0;
      cmp_ctx();
      ret(1, 0);
      $display("reset test done");
      print_verdict;
   end
endmodule // return_and_rotate_instr_exec_test
`default_nettype wire
